// File: tb/dpcc_refsrc.sv
// Model of the external clock source feeding the reference input
module dpcc_refsrc (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  output logic            o_ref
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff;
  logic       ref_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Stands still low outside a run, like a gated source
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n || !i_run) begin
      cnt_ff <= 8'h00;
      ref_ff <= 1'b0;
    end else if (cnt_ff == i_half - 8'h01) begin
      cnt_ff <= 8'h00;
      ref_ff <= ~ref_ff;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign o_ref = ref_ff;
endmodule

// File: tb/tb_dac_pll_clock_control.sv
// Testbench of the clock control block: bus tasks and scenario sequence
`include "dpcc_consts.svh"
module tb_dac_pll_clock_control
  import dpcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk;
  logic            rst_n;
  logic [7:0]      address;
  logic            rd;
  logic            wr;
  logic [31:0]     wdata;
  logic [3:0]      be;
  logic [31:0]     rdata;
  logic            wait_req;
  logic            lock;
  logic            irq;
  dpcc_clk_en_type clk_en;
  logic            ref_clk;
  logic            ref_run;
  logic [7:0]      ref_half;
  int              n_errors;
  int              compares;
  int              cnt [4];
  int              nsync;
  int              top;
  bit              cnt_on;
  logic            ce;
  logic [3:0]      en_v;

  dpcc_top #(.PER_W(16)) dpcc_top_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_reference_clock_input(ref_clk), .i_address(address),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(be),
    .o_readdata(rdata), .o_waitrequest(wait_req),
    .o_loop_lock_output(lock), .o_irq(irq), .o_clk_en(clk_en));

  dpcc_refsrc dpcc_refsrc_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_run(ref_run), .i_half(ref_half),
    .o_ref(ref_clk));

  assign en_v = clk_en;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Enable pulse counters; 1x pulses must land on a top-rate pulse
  always @(posedge clk) begin
    if (cnt_on) begin
      for (int k = 0; k < 4; k++) cnt[k] += en_v[k];
      if (en_v[0] && !en_v[top]) nsync++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [31:0] wd, input logic [3:0] b,
                     output logic [31:0] q);
    @(posedge clk);
    address <= {idx, 2'b00};
    rd      <= !w;
    wr      <= w;
    wdata   <= wd;
    be      <= b;
    // Waits as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d,
                        input logic [3:0] b = 4'hF);
    logic [31:0] q;
    bus(1'b1, idx, d, b, q);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, 4'hF, q);
    check(q, exp);
  endtask

  // Window of whole reference periods, so divider phase does not matter
  task automatic count_periods(input int n);
    repeat (2) @(negedge ref_clk);
    foreach (cnt[k]) cnt[k] = 0;
    nsync = 0;
    cnt_on = 1'b1;
    repeat (n) @(negedge ref_clk);
    cnt_on = 1'b0;
  endtask

  task automatic wait_lock(input logic v);
    int n;
    n = 0;
    while (lock !== v && n < 600) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, lock}, {31'h0, v});
  endtask

  task automatic summarize;
    $display("Errors: %0d, comparisons: %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (12500) @(posedge clk);
    n_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    summarize;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]      cfg;
    dpcc_clk_en_type snap;
    rst_n = 1'b0; rd = 1'b0; wr = 1'b0; address = 8'h00; wdata = 32'h0;
    be = 4'h0; ref_run = 1'b0; ref_half = 8'h05; cnt_on = 1'b0; top = 0;
    n_errors = 0; compares = 0; nsync = 0; ce = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(`DPCC_IDX_STATUS, 32'h0);
    rd_chk(`DPCC_IDX_CLKCFG, 32'h0);
    rd_chk(`DPCC_IDX_IRQ_STS, 32'h0);
    rd_chk(`DPCC_IDX_IRQ_MSK, 32'h0);
    rd_chk(`DPCC_IDX_VCO_MUL, 32'h1);
    rd_chk(`DPCC_IDX_REF_PER, 32'h0000FFFF);
    wr_reg(6'h03, 32'hFF);
    rd_chk(6'h03, 32'h0);
    wr_reg(`DPCC_IDX_CLKCFG, 32'hFF, 4'hE);
    rd_chk(`DPCC_IDX_CLKCFG, 32'h0);
    // Every interpolation, prescaler and zero-stuff code
    for (int c = 0; c < 32; c++) begin
      wr_reg(`DPCC_IDX_CLKCFG, 32'(c));
      rd_chk(`DPCC_IDX_CLKCFG, 32'(c));
      rd_chk(`DPCC_IDX_VCO_MUL, 32'((1 << c[1:0]) * (1 << c[3:2])
                                    * (c[4] ? 2 : 1)));
    end
    // Loop off: input is the converter-rate clock
    ref_run <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr_reg(`DPCC_IDX_CLKCFG, 32'(c));
      top = c;
      count_periods(16);
      check(32'(cnt[c]), 32'd16);
      check(32'(cnt[0]), 32'(16 >> c));
      check(32'(nsync), 32'd0);
      check({31'h0, lock}, 32'h0);
    end
    // Loop on, prescaler chosen to keep the period above the multiplier
    ref_half <= 8'd10;
    for (int j = 0; j < 2; j++) begin
      cfg = j ? 8'h95 : 8'h81;
      wr_reg(`DPCC_IDX_CLKCFG, {24'h0, cfg});
      repeat (2) @(posedge clk);
      check({31'h0, lock}, 32'h0);
      rd_chk(`DPCC_IDX_VCO_MUL, j ? 32'd8 : 32'd2);
      top = 1;
      wait_lock(1'b1);
      rd_chk(`DPCC_IDX_STATUS, 32'h2);
      rd_chk(`DPCC_IDX_REF_PER, 32'd20);
      count_periods(8);
      check(32'(cnt[1]), 32'd16);
      check(32'(cnt[0]), 32'd8);
      check(32'(nsync), 32'd0);
    end
    // Interrupts: loss by reference timeout, masking, clearing, gain
    wr_reg(`DPCC_IDX_IRQ_STS, 32'h3);
    rd_chk(`DPCC_IDX_IRQ_STS, 32'h0);
    ref_run <= 1'b0;
    wait_lock(1'b0);
    rd_chk(`DPCC_IDX_IRQ_STS, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr_reg(`DPCC_IDX_IRQ_MSK, 32'h2);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    rd_chk(`DPCC_IDX_IRQ_MSK, 32'h2);
    wr_reg(`DPCC_IDX_IRQ_STS, 32'h1);
    rd_chk(`DPCC_IDX_IRQ_STS, 32'h2);
    wr_reg(`DPCC_IDX_IRQ_STS, 32'h2);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rd_chk(`DPCC_IDX_IRQ_STS, 32'h0);
    ref_run <= 1'b1;
    wait_lock(1'b1);
    rd_chk(`DPCC_IDX_IRQ_STS, 32'h1);
    check({31'h0, irq}, 32'h0);
    // Clock enable low freezes lock and the derived enables
    @(posedge clk);
    ce <= 1'b0;
    @(posedge clk);
    snap = clk_en;
    repeat (20) @(posedge clk);
    check({31'h0, lock}, 32'h1);
    check({28'h0, clk_en}, {28'h0, snap});
    ce <= 1'b1;
    summarize;
  end
endmodule

// File: verilog/dpcc_clkdiv.sv
// Divider that derives phase-aligned 1x..8x clock enables from the top tick
module dpcc_clkdiv
  import dpcc_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_ce,
  input  wire logic            i_tick,
  input  wire logic            i_align,
  input  wire logic [1:0]      i_interp_sel,
  output dpcc_clk_en_type      o_en
);
  logic [2:0]      phase_ff;
  logic [2:0]      nxt_phase;
  logic [2:0]      mask;
  logic [2:0]      cur;
  logic [3:0]      fire;
  dpcc_clk_en_type en_ff;

  assign mask = 3'(dpcc_ratio(i_interp_sel) - 4'h1);
  assign cur  = i_align ? 3'h0 : ((phase_ff + 3'h1) & mask);
  assign nxt_phase = i_tick ? cur : (i_align ? mask : phase_ff);

  // Rate 2^j fires on phases that are multiples of interp / 2^j
  genvar j;
  generate
    for (j = 0; j < 4; j++) begin : g_rate
      logic [2:0] sub_mask;
      assign sub_mask = 3'(mask >> j);
      assign fire[j] = i_tick && (j <= i_interp_sel)
                       && ((cur & sub_mask) == 3'h0);
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_ff <= 3'h7;
      en_ff    <= '0;
    end else if (i_ce) begin
      phase_ff <= nxt_phase;
      en_ff    <= {fire[3], fire[2], fire[1], fire[0]};
    end
  end

  assign o_en = en_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Enables were built from the ratio of the previous cycle
  a_slow_with_fast: assert property (
    o_en.en1 |-> ($past(i_interp_sel) < 2'h1 || o_en.en2)
              && ($past(i_interp_sel) < 2'h2 || o_en.en4)
              && ($past(i_interp_sel) < 2'h3 || o_en.en8))
    else $error("1x enable without faster enables");
  a_top_rate_tick: assert property (
    (i_ce && i_tick && i_interp_sel == 2'h3) |=> o_en.en8)
    else $error("8x enable missed a tick");
  a_no_tick_quiet: assert property (
    (i_ce && !i_tick) |=> o_en == '0)
    else $error("enable without a tick");
  c_eight_x: cover property (i_interp_sel == 2'h3 && o_en.en1);
endmodule

// File: verilog/dpcc_consts.svh
// Offsets, field positions, reset values and timing counts of clock control
`ifndef DPCC_CONSTS_SVH
`define DPCC_CONSTS_SVH
`define DPCC_IDX_STATUS     6'h00
`define DPCC_IDX_CLKCFG     6'h02
`define DPCC_IDX_IRQ_STS    6'h10
`define DPCC_IDX_IRQ_MSK    6'h11
`define DPCC_IDX_VCO_MUL    6'h12
`define DPCC_IDX_REF_PER    6'h13
`define DPCC_BIT_LOCK       1
`define DPCC_BIT_LOOP_EN    7
`define DPCC_BIT_ZSTUFF     4
`define DPCC_FLD_PRESC_LSB  2
`define DPCC_FLD_INTERP_LSB 0
`define DPCC_CLKCFG_RST     8'h00
`define DPCC_IRQ_RST        2'h0
`define DPCC_IRQ_GAIN       0
`define DPCC_IRQ_LOSS       1
`define DPCC_LOCK_TOL       16'h0002
`define DPCC_LOCK_EDGES     4'h8
`define DPCC_CLK_MHZ        125
`define DPCC_REF_TMO_NS     2000
`define DPCC_REF_TMO_CYC    ((`DPCC_REF_TMO_NS * `DPCC_CLK_MHZ) / 1000)
`endif

// File: verilog/dpcc_pkg.sv
// Types and shared decoding of the clock control block
package dpcc_pkg;
  typedef struct packed {
    logic       loop_en;
    logic       zstuff;
    logic [1:0] presc_sel;
    logic [1:0] interp_sel;
  } dpcc_cfg_type;

  typedef struct packed {
    logic en8;
    logic en4;
    logic en2;
    logic en1;
  } dpcc_clk_en_type;

  typedef enum logic [1:0] {
    DPCC_ST_IDLE = 2'b00,
    DPCC_ST_ACQ  = 2'b01,
    DPCC_ST_LOCK = 2'b10
  } dpcc_lock_st_type;

  // Two-bit code to ratio 1, 2, 4 or 8
  function automatic logic [3:0] dpcc_ratio(input logic [1:0] sel);
    dpcc_ratio = 4'h1 << sel;
  endfunction
endpackage

// File: verilog/dpcc_top.sv
// Clock control: reference measure, loop model, lock, dividers, Avalon regs
`include "dpcc_consts.svh"
module dpcc_top
  import dpcc_pkg::*;
#(
  parameter int PER_W = 16
)
(
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_ce,
  input  wire logic            i_reference_clock_input,
  input  wire logic [7:0]      i_address,
  input  wire logic            i_read,
  input  wire logic            i_write,
  input  wire logic [31:0]     i_writedata,
  input  wire logic [3:0]      i_byteenable,
  output logic [31:0]          o_readdata,
  output logic                 o_waitrequest,
  output logic                 o_loop_lock_output,
  output logic                 o_irq,
  output dpcc_clk_en_type      o_clk_en
);
  generate
    if (PER_W < 9 || PER_W > 31) begin : g_bad_width
      $error("PER_W must lie between 9 and 31");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_ff;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  dpcc_cfg_type     cfg_ff;
  logic [1:0]       sts_ff;
  logic [1:0]       msk_ff;
  logic             wait_ff;
  logic [31:0]      rdata_ff;
  logic             irq_ff;
  logic             lock_ff;

  logic [5:0]       idx;
  logic             acc_rd;
  logic             acc_wr;
  logic             wr_cfg;
  logic             wr_sts;
  logic             wr_msk;
  logic [31:0]      rd_mux;

  assign idx    = i_address[7:2];
  assign acc_rd = i_read && !wait_ff;
  assign acc_wr = i_write && !wait_ff && i_byteenable[0];
  assign wr_cfg = acc_wr && (idx == `DPCC_IDX_CLKCFG);
  assign wr_sts = acc_wr && (idx == `DPCC_IDX_IRQ_STS);
  assign wr_msk = acc_wr && (idx == `DPCC_IDX_IRQ_MSK);

  ////////////////////////////////////////////////////////////////////////////
  // Reference edge and period measurement
  logic             ref_d_ff;
  logic             ref_edge;
  logic [PER_W-1:0] cnt_ff;
  logic [PER_W-1:0] per_ff;
  logic [PER_W-1:0] nxt_cnt;
  logic [PER_W-1:0] cur_per;
  logic             ref_lost;
  logic             per_match;

  assign ref_edge  = i_reference_clock_input && !ref_d_ff;
  assign ref_lost  = (cnt_ff == PER_W'(`DPCC_REF_TMO_CYC));
  assign cur_per   = cnt_ff + PER_W'(1);
  assign nxt_cnt   = ref_edge ? '0 : (ref_lost ? cnt_ff : cur_per);
  assign per_match = (cur_per >= per_ff ? cur_per - per_ff
                                        : per_ff - cur_per)
                     <= PER_W'(`DPCC_LOCK_TOL);

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator model: ticks at reference rate times the loop multiplier
  logic [7:0]       prod;
  logic [7:0]       mult;
  logic [4:0]       vdiv;
  logic [PER_W-1:0] acc_ff;
  logic [PER_W:0]   acc_sum;
  logic             vco_tick;
  logic [PER_W-1:0] nxt_acc;
  logic [4:0]       pre_ff;
  logic [4:0]       nxt_pre;
  logic             pre_wrap;
  logic             dac_tick;
  logic             align;

  assign prod = 8'(dpcc_ratio(cfg_ff.interp_sel)
                   * dpcc_ratio(cfg_ff.presc_sel));
  assign mult = cfg_ff.zstuff ? {prod[6:0], 1'b0} : prod;
  assign vdiv = cfg_ff.zstuff ? {dpcc_ratio(cfg_ff.presc_sel), 1'b0}
                              : {1'b0, dpcc_ratio(cfg_ff.presc_sel)};
  // Restart from zero on each edge so the phase tracks the reference
  assign acc_sum  = {1'b0, (ref_edge ? PER_W'(0) : acc_ff)}
                    + (PER_W+1)'(mult);
  assign vco_tick = cfg_ff.loop_en && (acc_sum >= {1'b0, per_ff});
  assign nxt_acc  = vco_tick ? PER_W'(acc_sum - {1'b0, per_ff})
                             : PER_W'(acc_sum);
  // Prescaler brings the oscillator down to the converter rate
  assign pre_wrap = vco_tick && ((ref_edge ? 5'h0 : pre_ff) + 5'h1 == vdiv);
  assign nxt_pre  = ref_edge ? (vco_tick ? 5'h1 : 5'h0)
                             : (pre_wrap ? 5'h0 : pre_ff + 5'(vco_tick));
  // Loop off: each input edge is itself a converter-rate edge
  assign dac_tick = cfg_ff.loop_en ? pre_wrap : ref_edge;
  assign align    = cfg_ff.loop_en && ref_edge;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_ff <= 1'b0;
      cnt_ff   <= '0;
      per_ff   <= '1;
      acc_ff   <= '0;
      pre_ff   <= 5'h0;
    end else if (i_ce) begin
      ref_d_ff <= i_reference_clock_input;
      cnt_ff   <= nxt_cnt;
      if (ref_edge) begin
        per_ff <= cur_per;
      end
      acc_ff   <= cfg_ff.loop_en ? nxt_acc : '0;
      pre_ff   <= cfg_ff.loop_en ? nxt_pre : 5'h0;
    end
  end

  dpcc_clkdiv u_div (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_ce         (i_ce),
    .i_tick       (dac_tick),
    .i_align      (align),
    .i_interp_sel (cfg_ff.interp_sel),
    .o_en         (o_clk_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lock detection: a run of steady reference periods
  dpcc_lock_st_type st_ff;
  dpcc_lock_st_type nxt_st;
  logic [3:0]       run_ff;
  logic [3:0]       nxt_run;
  logic             nxt_lock;

  always_comb begin
    nxt_st  = st_ff;
    nxt_run = run_ff;
    case (st_ff)
      DPCC_ST_IDLE: begin
        nxt_run = 4'h0;
        if (cfg_ff.loop_en && ref_edge) begin
          nxt_st = DPCC_ST_ACQ;
        end
      end
      DPCC_ST_ACQ: begin
        if (ref_edge) begin
          nxt_run = per_match ? run_ff + 4'h1 : 4'h0;
          if (per_match && run_ff + 4'h1 == `DPCC_LOCK_EDGES) begin
            nxt_st = DPCC_ST_LOCK;
          end
        end
      end
      DPCC_ST_LOCK: begin
        if (ref_edge && !per_match) begin
          nxt_st  = DPCC_ST_ACQ;
          nxt_run = 4'h0;
        end
      end
      default: nxt_st = DPCC_ST_IDLE;
    endcase
    // A changed ratio or a silent reference restarts acquisition
    if (!cfg_ff.loop_en || ref_lost || wr_cfg) begin
      nxt_st  = DPCC_ST_IDLE;
      nxt_run = 4'h0;
    end
  end

  assign nxt_lock = (nxt_st == DPCC_ST_LOCK);

  ////////////////////////////////////////////////////////////////////////////
  // Registers, events and interrupt
  logic [1:0] events;
  logic [1:0] nxt_sts;
  logic [1:0] nxt_msk;

  assign events  = {lock_ff && !nxt_lock, nxt_lock && !lock_ff};
  // Set wins over a write-one clear in the same cycle
  assign nxt_sts = (sts_ff & ~(wr_sts ? i_writedata[1:0] : 2'h0)) | events;
  assign nxt_msk = wr_msk ? i_writedata[1:0] : msk_ff;

  assign rd_mux =
    (idx == `DPCC_IDX_STATUS)  ? 32'(lock_ff) << `DPCC_BIT_LOCK :
    (idx == `DPCC_IDX_CLKCFG)  ? {24'h0, cfg_ff.loop_en, 2'h0,
                                  cfg_ff.zstuff, cfg_ff.presc_sel,
                                  cfg_ff.interp_sel} :
    (idx == `DPCC_IDX_IRQ_STS) ? {30'h0, sts_ff} :
    (idx == `DPCC_IDX_IRQ_MSK) ? {30'h0, msk_ff} :
    (idx == `DPCC_IDX_VCO_MUL) ? {24'h0, mult} :
    (idx == `DPCC_IDX_REF_PER) ? 32'(per_ff) : 32'h0;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff   <= dpcc_cfg_type'(6'(`DPCC_CLKCFG_RST));
      sts_ff   <= `DPCC_IRQ_RST;
      msk_ff   <= `DPCC_IRQ_RST;
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0;
      irq_ff   <= 1'b0;
      lock_ff  <= 1'b0;
      st_ff    <= DPCC_ST_IDLE;
      run_ff   <= 4'h0;
    end else if (i_ce) begin
      // One wait cycle, then the answer for exactly one cycle
      wait_ff  <= !(wait_ff && (i_read || i_write));
      if (wait_ff && i_read) begin
        rdata_ff <= rd_mux;
      end
      if (wr_cfg) begin
        cfg_ff <= {i_writedata[`DPCC_BIT_LOOP_EN],
                   i_writedata[`DPCC_BIT_ZSTUFF],
                   i_writedata[`DPCC_FLD_PRESC_LSB +: 2],
                   i_writedata[`DPCC_FLD_INTERP_LSB +: 2]};
      end
      sts_ff   <= nxt_sts;
      msk_ff   <= nxt_msk;
      irq_ff   <= |(nxt_sts & nxt_msk);
      lock_ff  <= nxt_lock;
      st_ff    <= nxt_st;
      run_ff   <= nxt_run;
    end
  end

  assign o_readdata         = rdata_ff;
  assign o_waitrequest      = wait_ff;
  assign o_loop_lock_output = lock_ff;
  assign o_irq              = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] vcnt_ff;
  logic       dac_d_ff;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      vcnt_ff  <= 8'h0;
      dac_d_ff <= 1'b0;
    end else if (i_ce) begin
      vcnt_ff  <= ref_edge ? 8'(vco_tick) : vcnt_ff + 8'(vco_tick);
      dac_d_ff <= ref_edge && !cfg_ff.loop_en;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_direct_input: assert property (
    dac_d_ff |-> ($past(cfg_ff.interp_sel) != 2'h0 || o_clk_en.en1))
    else $error("direct edge did not reach 1x");
  // Edge restarts the phase: only this cycle's step remains
  a_loop_rephase: assert property (
    (i_ce && align) |=> acc_ff == PER_W'($past(mult))
                       - ($past(vco_tick) ? $past(per_ff) : PER_W'(0)))
    else $error("oscillator not rephased");
  a_lock_pin_bit: assert property (
    (i_ce && st_ff == DPCC_ST_LOCK) |-> ##1
      (o_loop_lock_output == $past(nxt_lock)))
    else $error("lock pin lags state");
  a_lock_needs_loop: assert property (
    (i_ce && !cfg_ff.loop_en) |=> !o_loop_lock_output)
    else $error("lock shown with loop off");
  a_vco_count: assert property (
    (st_ff == DPCC_ST_LOCK && ref_edge && cur_per == per_ff
     && {8'h0, mult} <= 16'(per_ff)) |-> vcnt_ff == mult)
    else $error("oscillator ticks per period wrong");
  a_irq_level: assert property (o_irq == |(sts_ff & msk_ff))
    else $error("interrupt level mismatch");
  a_gain_sticky: assert property (
    (i_ce && events[`DPCC_IRQ_GAIN]) |=> sts_ff[`DPCC_IRQ_GAIN])
    else $error("lock gain not recorded");
  a_answer_once: assert property ((i_ce && !o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest low twice");
  c_locked: cover property (st_ff == DPCC_ST_ACQ ##1 st_ff == DPCC_ST_LOCK);
  c_lost: cover property (events[`DPCC_IRQ_LOSS]);
  c_zstuff_lock: cover property (cfg_ff.zstuff && o_loop_lock_output);
endmodule
